// ===== src/pin_sync.sv
// two-flop synchroniser for asynchronous pins
`default_nettype none
module pin_sync #(
  parameter int          W   = 12,
  parameter logic [11:0] RST = 12'h000
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        meta[i] <= RST[i];
        q_o[i]  <= RST[i];
      end else begin
        meta[i] <= d_i[i];
        q_o[i]  <= meta[i];
      end
    end
  end

endmodule : pin_sync
`default_nettype wire

// ===== src/rs485_dir_defs.svh
// constants for the rs485 direction control block
// Overview of operation
// - In the handshake modes the line driver is on while the rs232 handshake input is asserted.
// - In the handshake modes the line driver is off (high impedance) while the handshake input is negated.
// - In the echo modes the bus receive path stays enabled at all times.
// - In the no-echo modes the receive path is off while the driver is on, and on while the driver is off.
// - In the automatic modes transmit activity on the rs232 data input turns the driver on by itself.
// - In the automatic modes the driver returns to high impedance after each transmission ends.
// - The automatic release delay is about 10 us after the last activity and can be changed.
// - Switches a, b, c off with d on select the rs422 / 4-wire master mode; d on, e and h off in every mode.
// - In the rs485 modes switch a on selects no-echo and switch a off selects echo.
// - Switch c alone selects handshake keying and switch b alone selects automatic keying.
// - In master mode all drivers and receivers stay enabled, one data and one handshake channel each way.
// - The termination network is connected only when switches 6 and 7 are both closed.
`ifndef RS485_DIR_DEFS_SVH
`define RS485_DIR_DEFS_SVH

// timing
`define CLK_PERIOD_NS   50
`define RELEASE_TIME_NS 10000
`define RELEASE_CYCLES  (`RELEASE_TIME_NS / `CLK_PERIOD_NS)
`define DELAY_W         16
`define DELAY_RST       16'(`RELEASE_CYCLES)

// pin synchroniser layout and reset levels (data lines idle high)
`define SYNC_W          12
`define SYNC_RST        12'h500

// register port
`define ADDR_W          4
`define DATA_W          32
`define REG_DELAY       4'h0
`define REG_STATUS      4'h4
`define REG_KEYCNT      4'h8

// status register fields
`define ST_MODE_LSB     0
`define ST_DRV_BIT      3
`define ST_RX_BIT       4
`define ST_TERM_BIT     5
`define ST_ERR_BIT      6
`define ST_HS_BIT       7

`endif

// ===== src/rs485_dir_pkg.sv
// types for the rs485 direction control block
`default_nettype none
package rs485_dir_pkg;

  // operating mode from the switch bank
  typedef enum logic [2:0] {
    MODE_MASTER,
    MODE_HS_ECHO,
    MODE_HS_NOECHO,
    MODE_AUTO_ECHO,
    MODE_AUTO_NOECHO,
    MODE_BAD
  } mode_e;

  // line driver keying state
  typedef enum logic [1:0] {
    DRV_OFF,
    DRV_ON,
    DRV_HOLD
  } drv_state_e;

endpackage : rs485_dir_pkg
`default_nettype wire

// ===== src/rs485_direction_control.sv
// rs485 direction control: mode decode, driver keying, receive gating
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "rs485_dir_defs.svh"
`default_nettype none
module rs485_direction_control (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // configuration switches, high = on / closed
  input  wire logic                switch_mode_a_i,
  input  wire logic                switch_mode_b_i,
  input  wire logic                switch_mode_c_i,
  input  wire logic                switch_mode_d_i,
  input  wire logic                switch_mode_e_i,
  input  wire logic                switch_mode_h_i,
  input  wire logic                term_sw6_i,
  input  wire logic                term_sw7_i,
  // rs232 side
  input  wire logic                rs232_txd_i,
  input  wire logic                rs232_hs_i,
  output logic                     rs232_rxd_o,
  output logic                     rs232_hs_o,
  // rs485 / rs422 side
  output logic                     bus_data_o,
  output logic                     bus_drv_en_o,
  input  wire logic                bus_data_i,
  output logic                     bus_rx_en_o,
  output logic                     bus_hs_o,
  output logic                     bus_hs_en_o,
  input  wire logic                bus_hs_i,
  output logic                     term_en_o,
  // status
  output var rs485_dir_pkg::mode_e mode_o,
  output logic                     cfg_err_o,
  // register port
  input  wire logic [`ADDR_W-1:0]  addr_i,
  input  wire logic [`DATA_W-1:0]  wr_data_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [`DATA_W-1:0]  rd_data_o
);
  import rs485_dir_pkg::*;

  // synchronised pins
  logic [`SYNC_W-1:0]  pins_raw;
  logic [`SYNC_W-1:0]  pins_s;
  logic                sw_a;
  logic                sw_b;
  logic                sw_c;
  logic                sw_d;
  logic                sw_e;
  logic                sw_h;
  logic                sw6_s;
  logic                sw7_s;
  logic                txd_s;
  logic                hs_s;
  logic                bus_rx_s;
  logic                bus_hs_s;

  // control state
  mode_e               next_mode;
  drv_state_e          drv_state;
  drv_state_e          next_state;
  logic [`DELAY_W-1:0] hold_cnt;
  logic [`DELAY_W-1:0] next_hold;
  logic [`DELAY_W-1:0] delay_q;
  logic [`DELAY_W-1:0] delay_eff;
  logic [`DELAY_W-1:0] hold_load;
  logic [`DELAY_W-1:0] keycnt;
  logic                tx_change;
  logic                next_drv;
  logic                next_rx_en;
  logic                key_event;
  logic [`DATA_W-1:0]  status_word;

  function automatic logic is_auto(mode_e m);
    return (m == MODE_AUTO_ECHO) || (m == MODE_AUTO_NOECHO);
  endfunction : is_auto

  function automatic logic is_hs(mode_e m);
    return (m == MODE_HS_ECHO) || (m == MODE_HS_NOECHO);
  endfunction : is_hs

  function automatic logic is_echo(mode_e m);
    return (m == MODE_HS_ECHO) || (m == MODE_AUTO_ECHO);
  endfunction : is_echo

  function automatic logic is_noecho(mode_e m);
    return (m == MODE_HS_NOECHO) || (m == MODE_AUTO_NOECHO);
  endfunction : is_noecho

  // every pin passes two flops before use
  assign pins_raw = {bus_hs_i, bus_data_i, rs232_hs_i, rs232_txd_i,
                     term_sw7_i, term_sw6_i, switch_mode_h_i, switch_mode_e_i,
                     switch_mode_d_i, switch_mode_c_i, switch_mode_b_i, switch_mode_a_i};

  pin_sync #(
    .W   (`SYNC_W),
    .RST (`SYNC_RST)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (pins_raw),
    .q_o     (pins_s)
  );

  assign {bus_hs_s, bus_rx_s, hs_s, txd_s, sw7_s, sw6_s,
          sw_h, sw_e, sw_d, sw_c, sw_b, sw_a} = pins_s;

  // switch bank decode
  always_comb begin
    next_mode = MODE_BAD;
    if (sw_d && !sw_e && !sw_h) begin
      unique case ({sw_b, sw_c})
        2'b00: next_mode = sw_a ? MODE_BAD : MODE_MASTER;
        2'b01: next_mode = sw_a ? MODE_HS_NOECHO : MODE_HS_ECHO;
        2'b10: next_mode = sw_a ? MODE_AUTO_NOECHO : MODE_AUTO_ECHO;
        2'b11: next_mode = MODE_BAD;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_o    <= MODE_BAD;
      cfg_err_o <= 1'b1;
    end else begin
      mode_o    <= next_mode;
      cfg_err_o <= (next_mode == MODE_BAD);
    end
  end

  // activity: any level change on the transmit data line
  assign tx_change = (txd_s != bus_data_o);

  // a zero delay still holds the driver one cycle
  assign delay_eff = (delay_q == 16'h0000) ? 16'h0001 : delay_q;
  assign hold_load = delay_eff - 16'h0001;

  // driver keying
  always_comb begin
    next_state = DRV_OFF;
    next_hold  = 16'h0000;
    unique case (mode_o)
      MODE_MASTER: begin
        next_state = DRV_ON;
      end
      MODE_HS_ECHO, MODE_HS_NOECHO: begin
        next_state = hs_s ? DRV_ON : DRV_OFF;
      end
      MODE_AUTO_ECHO, MODE_AUTO_NOECHO: begin
        if (tx_change) begin
          next_state = DRV_HOLD;
          next_hold  = hold_load;
        end else if (drv_state == DRV_HOLD && hold_cnt != 16'h0000) begin
          next_state = DRV_HOLD;
          next_hold  = hold_cnt - 16'h0001;
        end else begin
          next_state = DRV_OFF;
        end
      end
      default: begin
        next_state = DRV_OFF;
      end
    endcase
  end

  assign next_drv = (next_state != DRV_OFF);

  // receive gating follows the next driver state
  always_comb begin
    if (is_noecho(mode_o)) begin
      next_rx_en = !next_drv;
    end else begin
      next_rx_en = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      drv_state <= DRV_OFF;
      hold_cnt  <= 16'h0000;
    end else begin
      drv_state <= next_state;
      hold_cnt  <= next_hold;
    end
  end

  // bus side data and enables
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_data_o   <= 1'b1;
      bus_drv_en_o <= 1'b0;
      bus_rx_en_o  <= 1'b1;
      rs232_rxd_o  <= 1'b1;
    end else begin
      bus_data_o   <= txd_s;
      bus_drv_en_o <= next_drv;
      bus_rx_en_o  <= next_rx_en;
      rs232_rxd_o  <= next_rx_en ? bus_rx_s : 1'b1;
    end
  end

  // handshake channel, master mode only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_hs_o    <= 1'b0;
      bus_hs_en_o <= 1'b0;
      rs232_hs_o  <= 1'b0;
    end else begin
      bus_hs_o    <= hs_s;
      bus_hs_en_o <= (mode_o == MODE_MASTER);
      rs232_hs_o  <= (mode_o == MODE_MASTER) ? bus_hs_s : 1'b0;
    end
  end

  // termination network
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      term_en_o <= 1'b0;
    end else begin
      term_en_o <= sw6_s && sw7_s;
    end
  end

  // release delay register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      delay_q <= `DELAY_RST;
    end else if (wr_i && addr_i == `REG_DELAY) begin
      delay_q <= wr_data_i[`DELAY_W-1:0];
    end
  end

  // keying counter, a count with a clearing write in the same cycle leaves 1
  assign key_event = next_drv && !bus_drv_en_o;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      keycnt <= 16'h0000;
    end else if (key_event) begin
      keycnt <= (wr_i && addr_i == `REG_KEYCNT) ? 16'h0001 : keycnt + 16'h0001;
    end else if (wr_i && addr_i == `REG_KEYCNT) begin
      keycnt <= 16'h0000;
    end
  end

  always_comb begin
    status_word                                = 32'h0000_0000;
    status_word[`ST_MODE_LSB+2:`ST_MODE_LSB]   = mode_o;
    status_word[`ST_DRV_BIT]                   = bus_drv_en_o;
    status_word[`ST_RX_BIT]                    = bus_rx_en_o;
    status_word[`ST_TERM_BIT]                  = term_en_o;
    status_word[`ST_ERR_BIT]                   = cfg_err_o;
    status_word[`ST_HS_BIT]                    = hs_s;
  end

  // read data stand for one cycle only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        `REG_DELAY:  rd_data_o <= {16'h0000, delay_q};
        `REG_STATUS: rd_data_o <= status_word;
        `REG_KEYCNT: rd_data_o <= {16'h0000, keycnt};
        default:     rd_data_o <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_o <= 32'h0000_0000;
    end
  end

  // helpers for the checks below
  logic [`DELAY_W-1:0] quiet_run;
  logic                dly_touched;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      quiet_run <= 16'h0000;
    end else if (tx_change) begin
      quiet_run <= 16'h0000;
    end else if (quiet_run != 16'hffff) begin
      quiet_run <= quiet_run + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dly_touched <= 1'b0;
    end else if (wr_i && addr_i == `REG_DELAY) begin
      dly_touched <= 1'b1;
    end else if (tx_change) begin
      dly_touched <= 1'b0;
    end
  end

  hs_key_on_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_hs(mode_o) && hs_s) |=> bus_drv_en_o)
    else $error("driver not on with handshake asserted");

  hs_key_off_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_hs(mode_o) && !hs_s) |=> !bus_drv_en_o)
    else $error("driver not off with handshake negated");

  echo_rx_on_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_echo(mode_o) && $stable(mode_o)) |=> (bus_rx_en_o && rs232_rxd_o == $past(bus_rx_s)))
    else $error("echo mode receive path not open");

  noecho_gate_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    is_noecho(mode_o) |=> (bus_rx_en_o != bus_drv_en_o))
    else $error("no-echo receive gate wrong");

  auto_key_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_auto(mode_o) && tx_change) |=> (bus_drv_en_o && bus_data_o == $past(txd_s)))
    else $error("driver not keyed by transmit activity");

  auto_drop_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_auto(mode_o) && drv_state == DRV_HOLD && hold_cnt == 16'h0000 && !tx_change)
      |=> (!bus_drv_en_o && bus_rx_en_o))
    else $error("driver not released after transmission");

  release_time_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_auto(mode_o) && $fell(bus_drv_en_o) && $past(drv_state) == DRV_HOLD && !dly_touched)
      |-> (quiet_run == delay_eff))
    else $error("release delay count wrong");

  master_decode_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!sw_a && !sw_b && !sw_c && sw_d && !sw_e && !sw_h) |=> (mode_o == MODE_MASTER && !cfg_err_o))
    else $error("master mode not decoded");

  echo_select_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (sw_d && !sw_e && !sw_h && (sw_b != sw_c)) |=> (is_noecho(mode_o) == $past(sw_a)))
    else $error("echo option not decoded");

  method_select_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (sw_d && !sw_e && !sw_h && (sw_b != sw_c)) |=> (is_hs(mode_o) == $past(sw_c)))
    else $error("keying method not decoded");

  master_on_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode_o == MODE_MASTER) |=> (bus_drv_en_o && bus_rx_en_o && bus_hs_en_o))
    else $error("master mode channels not all on");

  term_pins_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ($past(rst_n_i, 3) && $past(rst_n_i, 2) && $past(rst_n_i))
      |-> (term_en_o == ($past(term_sw6_i, 3) && $past(term_sw7_i, 3))))
    else $error("termination does not follow switches");

  quiet_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (is_auto(mode_o) && drv_state == DRV_HOLD && !dly_touched && (quiet_run + 16'h0001) < delay_eff)
      |=> bus_drv_en_o)
    else $error("driver dropped before quiet delay");

endmodule : rs485_direction_control
`default_nettype wire

// ===== verification/bus_node_model.sv
// far-side bus node model: resolves the rs485 data pair and the remote handshake pair
`default_nettype none
module bus_node_model (
  // clock
  input  wire logic clk_i,
  // block driver side
  input  wire logic drv_en_i,
  input  wire logic data_i,
  input  wire logic term_en_i,
  // remote node
  input  wire logic node_en_i,
  input  wire logic node_data_i,
  input  wire logic node_hs_i,
  // resolved lines
  output logic      bus_data_o,
  output logic      bus_hs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  always @(posedge clk_i) flip <= ~flip;
  // undriven, unterminated pair has no stable level
  always_comb begin
    if (drv_en_i) bus_data_o = data_i;
    else if (node_en_i) bus_data_o = node_data_i;
    else if (term_en_i) bus_data_o = 1'b1;
    else bus_data_o = flip;
  end
  assign bus_hs_o = node_en_i ? node_hs_i : flip;
endmodule : bus_node_model
`default_nettype wire

// ===== verification/rs485_direction_control_tb.sv
// self-checking bench for the rs485 direction control block
`include "rs485_dir_defs.svh"
`default_nettype none
module rs485_direction_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rs485_dir_pkg::*;
  logic               clk_i, rst_n_i, txd, hs_in, node_en, node_data, node_hs, sw6, sw7, wr, rd;
  logic [5:0]         sw;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] wr_data, rd_data, word;
  logic               rxd, hs_host, bus_data, drv_en, rx_en, bus_hs, hs_en, term_en, cfg_err, line, hs_line;
  mode_e              mode;
  int                 err_count, n_tests, seed, gap, k;
  logic               hv, nv, echo;

  rs485_direction_control u_rs485_direction_control (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .switch_mode_a_i(sw[5]), .switch_mode_b_i(sw[4]),
    .switch_mode_c_i(sw[3]), .switch_mode_d_i(sw[2]), .switch_mode_e_i(sw[1]), .switch_mode_h_i(sw[0]),
    .term_sw6_i(sw6), .term_sw7_i(sw7), .rs232_txd_i(txd), .rs232_hs_i(hs_in), .rs232_rxd_o(rxd),
    .rs232_hs_o(hs_host), .bus_data_o(bus_data), .bus_drv_en_o(drv_en), .bus_data_i(line),
    .bus_rx_en_o(rx_en), .bus_hs_o(bus_hs), .bus_hs_en_o(hs_en), .bus_hs_i(hs_line), .term_en_o(term_en),
    .mode_o(mode), .cfg_err_o(cfg_err), .addr_i(addr), .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rd_data));

  bus_node_model u_bus_node_model (
    .clk_i(clk_i), .drv_en_i(drv_en), .data_i(bus_data), .term_en_i(term_en), .node_en_i(node_en),
    .node_data_i(node_data), .node_hs_i(node_hs), .bus_data_o(line), .bus_hs_o(hs_line));

  // switch pattern {a,b,c,d,e,h} to mode
  function automatic mode_e exp_mode(input logic [5:0] s);
    case (s)
      6'h04: return MODE_MASTER;
      6'h0c: return MODE_HS_ECHO;
      6'h2c: return MODE_HS_NOECHO;
      6'h14: return MODE_AUTO_ECHO;
      6'h34: return MODE_AUTO_NOECHO;
      default: return MODE_BAD;
    endcase
  endfunction : exp_mode

  function automatic logic exp_rx(input logic ech, input logic drv);
    return ech | ~drv;
  endfunction : exp_rx

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : cycles

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    d = rd_data;
  endtask : reg_rd

  task automatic set_mode(input logic [5:0] s);
    @(posedge clk_i);
    sw <= s;
    cycles(4);
    check_word({29'h0, mode}, {29'h0, exp_mode(s)}, "mode");
    check_bit(cfg_err, exp_mode(s) == MODE_BAD, "cfg err");
  endtask : set_mode

  task automatic test_done();
    $display("errors %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // hang guard, far beyond the expected run
  initial begin
    #1000000;
    err_count++;
    test_done();
  end

  initial begin
    seed = 16;
    rst_n_i = 1'b0;
    sw = 6'h04;
    {sw6, sw7, hs_in, node_en, node_hs, wr, rd} = 7'h00;
    {txd, node_data} = 2'h3;
    addr = 4'h0;
    wr_data = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cycles(4);
    reg_rd(4'h0, word);
    check_word(word, 32'h0000_00c8, "delay reset");
    reg_rd(4'h8, word);
    // master mode after reset keys the driver once
    check_word(word, 32'h1, "keycnt after reset");
    reg_rd(4'hc, word);
    check_word(word, 32'h0, "unmapped");
    reg_wr(4'h4, 32'hffff_ffff);
    reg_rd(4'h4, word);
    check_word(word, 32'h0000_0018, "status ro");
    for (int i = 0; i < 10; i++) begin
      case (i)
        0: set_mode(6'h24);
        1: set_mode(6'h3c);
        2: set_mode(6'h00);
        3: set_mode(6'h06);
        4: set_mode(6'h05);
        5: set_mode(6'h14);
        6: set_mode(6'h34);
        7: set_mode(6'h0c);
        8: set_mode(6'h2c);
        default: set_mode(6'h04);
      endcase
      if (i < 5) begin
        check_bit(drv_en, 1'b0, "bad drv");
      end
    end
    node_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      hs_in <= 1'($random(seed));
      node_hs <= 1'($random(seed));
      cycles(4);
      check_bit(drv_en & rx_en & hs_en, 1'b1, "master en");
      check_bit(bus_hs, hs_in, "hs to bus");
      check_bit(hs_host, node_hs, "hs to host");
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {sw6, sw7} <= 2'(i);
      cycles(4);
      check_bit(term_en, i == 3, "termination");
    end
    for (int m = 0; m < 2; m++) begin
      echo = (m == 0);
      set_mode(echo ? 6'h0c : 6'h2c);
      for (int i = 0; i < 6; i++) begin
        hv = 1'($random(seed));
        nv = 1'($random(seed));
        @(posedge clk_i);
        hs_in <= hv;
        node_data <= nv;
        cycles(4);
        check_bit(drv_en, hv, "hs drv");
        check_bit(rx_en, exp_rx(echo, hv), "hs rx");
        cycles(3);
        check_bit(rxd, (!echo && hv) ? 1'b1 : (hv ? txd : nv), "hs rxd");
      end
    end
    node_en <= 1'b0;
    reg_wr(4'h0, 32'h4);
    reg_rd(4'h0, word);
    check_word(word, 32'h4, "delay rw");
    for (int m = 0; m < 2; m++) begin
      echo = (m == 0);
      set_mode(echo ? 6'h14 : 6'h34);
      reg_wr(4'h8, 32'h0);
      k = 3 + ($random(seed) & 3);
      for (int i = 0; i < k; i++) begin
        gap = 1 + ($random(seed) & 1);
        @(posedge clk_i);
        txd <= ~txd;
        if (i < k - 1) begin
          cycles(gap);
          if (i > 0) begin
            check_bit(drv_en, 1'b1, "auto hold");
            check_bit(rx_en, exp_rx(echo, 1'b1), "auto rx");
          end
        end
      end
      cycles(6);
      check_bit(drv_en, 1'b1, "auto before drop");
      check_bit(bus_data, txd, "bus data");
      check_bit(rxd, echo ? txd : 1'b1, "auto rxd");
      cycles(1);
      check_bit(drv_en, 1'b0, "auto drop");
      check_bit(rx_en, 1'b1, "auto rx back");
      reg_rd(4'h8, word);
      check_word(word, 32'h1, "one keying");
    end
    test_done();
  end
endmodule : rs485_direction_control_tb
`default_nettype wire
